// ### rtl/dpd_map.svh
// Offsets, instruction field positions, reset values for the decoder.
// Assumes an 18-bit word whose printed bit n sits at vector index 17-n.
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
// Register byte offsets
`define DPD_OFF_CTRL 4'h0
`define DPD_OFF_STAT2 4'h4
`define DPD_OFF_STAT3 4'h8
// Opcodes, bits 0-5 and the 9-bit skip codes, bits 0-8
`define DPD_OP_P1 6'h10
`define DPD_OP_P2 6'h11
`define DPD_OP_P3 6'h12
`define DPD_OP_SKIP 6'h13
`define DPD_SKIP_A 9'h098
`define DPD_SKIP_B 9'h09C
// Parameter one (vector index)
`define DPD_P1_STOP 11
`define DPD_P1_BRT_EN 10
`define DPD_P1_BRT_HI 9
`define DPD_P1_BRT_LO 7
`define DPD_P1_INC_EN 4
`define DPD_P1_INC_HI 3
// Parameter two enable positions; value bit is one below each
`define DPD_P2_ESC_EN 11
`define DPD_P2_FLASH_EN 9
`define DPD_P2_BORDER_EN 7
`define DPD_P2_TURN_EN 5
`define DPD_P2_PEN_EN 3
`define DPD_P2_MINOR_EN 1
// Parameter three
`define DPD_P3_GLOBAL 7
`define DPD_P3_HALT 6
`define DPD_P3_PEN 5
`define DPD_P3_BORDER 4
`define DPD_P3_BUTTON 3
// Control register bits (write one to act)
`define DPD_CTRL_RESUME 0
`define DPD_CTRL_CLR_PEN 1
`define DPD_CTRL_CLR_BORDER 2
`define DPD_CTRL_CLR_BUTTON 3
// Reset values and bus response codes
`define DPD_RST_BRT 3'h7
`define DPD_RST_INC 4'h1
`define DPD_RESP_OKAY 2'h0
`define DPD_RESP_SLVERR 2'h2
`endif

// ### rtl/dpd_pkg.sv
// Types for the display parameter decoder.
// Assumes the map header supplies all numeric constants.
package dpd_pkg;
   typedef struct packed {
      logic awready; logic wready; logic aw_got; logic w_got;
      logic [3:0] waddr; logic [31:0] wdata; logic [3:0] wstrb;
      logic bvalid; logic [1:0] bresp; logic arready; logic rvalid;
      logic [31:0] rdata; logic [1:0] rresp;
      logic [2:0] brightness; logic [3:0] increment;
      logic esc_cr; logic flash; logic border_det; logic turn;
      logic pen_det; logic minor_area; logic [1:0] line_type;
      logic irq_global; logic irq_halt; logic irq_pen;
      logic irq_border; logic irq_button;
      logic stop_flag; logic pen_flag; logic border_flag;
      logic button_flag; logic halt; logic irq_req; logic instr_ready;
      logic skip_a; logic skip_b; logic [1:0] pen_sync;
      logic [1:0] btn_sync;
   } dpd_state_t;
endpackage

// ### rtl/dpd_decoder.sv
// Parameter instruction decoder with AXI4-Lite status and control.
// Assumes fetch, datapath and border detect share aclk; the pen and
// pushbutton inputs are asynchronous pins.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dpd_map.svh"
module dpd_decoder #(
   parameter int INSTR_W = 18
) (
   input wire logic aclk, // 50 MHz clock
   input wire logic aresetn, // Synchronous reset, low
   input wire logic ce, // Clock enable, freezes all
   input wire logic [INSTR_W-1:0] instr_word, // Fetched word
   input wire logic instr_valid, // Word offered
   input wire logic border_exceed, // Datapath edge event
   input wire logic pen_hit_pin, // Light pen pin, async
   input wire logic button_pin, // Pushbutton pin, async
   input wire logic [3:0] s_axi_awaddr, // Write address
   input wire logic [2:0] s_axi_awprot, // Unused protection
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [3:0] s_axi_araddr, // Read address
   input wire logic [2:0] s_axi_arprot, // Unused protection
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic instr_ready, // Decoder takes words
   output logic halt, // Display file halted
   output logic stop_flag, // Stop skip condition
   output logic pen_flag, // Pen hit skip condition
   output logic border_flag, // Edge skip condition
   output logic button_flag, // Pushbutton skip condition
   output logic prog_irq_req, // Program interrupt request
   output logic skip_a_pulse, // Skip code 230 seen
   output logic skip_b_pulse, // Skip code 234 seen
   output logic [2:0] brightness, // 0 dark .. 7 bright
   output logic [3:0] increment, // Scale or plot step
   output logic esc_cr, // CR also ends strings
   output logic flash, // Blink later elements
   output logic border_detect, // Edge detect on
   output logic turn, // Rotate 90 degrees
   output logic pen_detect, // Light pen detect on
   output logic minor_area, // Offset area selected
   output logic [1:0] line_type // Dash pattern select
);

   // Refuse widths the field map cannot serve
   if (INSTR_W != 18) begin : g_bad_width
      $error("dpd_decoder: INSTR_W must be 18");
   end

   dpd_pkg::dpd_state_t s_r;
   dpd_pkg::dpd_state_t s_nxt;

   logic [5:0] opcode;
   logic [8:0] skip_code;
   logic take;
   logic do_write;
   logic ctrl_hit;
   logic [3:0] clr;
   logic pen_evt;
   logic btn_evt;
   logic [31:0] stat2;
   logic [31:0] stat3;

   // Opcode fields; printed bit 0 is the top of the word
   assign opcode = instr_word[17:12];
   assign skip_code = instr_word[17:9];
   assign take = instr_valid && s_r.instr_ready;

   // Write happens once address and data are both held
   assign do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   assign ctrl_hit = do_write && (s_r.waddr == `DPD_OFF_CTRL) &&
                     s_r.wstrb[0];
   assign clr = ctrl_hit ? s_r.wdata[3:0] : 4'h0;

   // Events from synchronised pins
   assign pen_evt = s_r.pen_sync[1];
   assign btn_evt = s_r.btn_sync[1];

   // Status word two: drawing parameters
   // brightness read-back
   assign stat2 = {17'h0, s_r.line_type, s_r.minor_area, s_r.pen_det,
                   s_r.border_det, s_r.esc_cr, s_r.turn, s_r.flash,
                   s_r.increment, s_r.brightness};

   // Status word three: flags and interrupt enables
   // stop flag read-back
   assign stat3 = {22'h0, s_r.irq_req, s_r.irq_button, s_r.irq_border,
                   s_r.irq_pen, s_r.irq_halt, s_r.irq_global,
                   s_r.button_flag, s_r.border_flag, s_r.pen_flag,
                   s_r.stop_flag};

   // Next-state logic for bus, decoder and flags
   always_comb begin
      s_nxt = s_r;
      s_nxt.skip_a = 1'b0;
      s_nxt.skip_b = 1'b0;
      s_nxt.pen_sync = {s_r.pen_sync[0], pen_hit_pin};
      s_nxt.btn_sync = {s_r.btn_sync[0], button_pin};

      // Write address and data captured in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr = {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (do_write) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         case (s_r.waddr)
            `DPD_OFF_CTRL, `DPD_OFF_STAT2, `DPD_OFF_STAT3: begin
               s_nxt.bresp = `DPD_RESP_OKAY;
            end
            default: begin
               s_nxt.bresp = `DPD_RESP_SLVERR;
            end
         endcase
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

      // Read address taken, data answered next cycle
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `DPD_RESP_OKAY;
         case ({s_axi_araddr[3:2], 2'b00})
            `DPD_OFF_CTRL: begin
               s_nxt.rdata = 32'h0000_0000;
            end
            `DPD_OFF_STAT2: begin
               s_nxt.rdata = stat2;
            end
            `DPD_OFF_STAT3: begin
               s_nxt.rdata = stat3;
            end
            default: begin
               s_nxt.rdata = 32'h0000_0000;
               s_nxt.rresp = `DPD_RESP_SLVERR;
            end
         endcase
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Software clears flags; a same-cycle event wins
      if (clr[`DPD_CTRL_RESUME]) begin
         s_nxt.stop_flag = 1'b0;
      end
      if (clr[`DPD_CTRL_CLR_PEN]) begin
         s_nxt.pen_flag = 1'b0;
      end
      if (clr[`DPD_CTRL_CLR_BORDER]) begin
         s_nxt.border_flag = 1'b0;
      end
      if (clr[`DPD_CTRL_CLR_BUTTON]) begin
         s_nxt.button_flag = 1'b0;
      end
      if (pen_evt && s_r.pen_det) begin
         s_nxt.pen_flag = 1'b1;
      end
      if (border_exceed && s_r.border_det) begin
         s_nxt.border_flag = 1'b1;
      end
      if (btn_evt) begin
         s_nxt.button_flag = 1'b1;
      end

      if (take) begin
         case (opcode)
            `DPD_OP_P1: begin
               if (instr_word[`DPD_P1_STOP]) begin
                  s_nxt.stop_flag = 1'b1;
               end
               if (instr_word[`DPD_P1_BRT_EN]) begin
                  s_nxt.brightness =
                     instr_word[`DPD_P1_BRT_HI:`DPD_P1_BRT_LO];
               end
               if (instr_word[`DPD_P1_INC_EN]) begin
                  s_nxt.increment = instr_word[`DPD_P1_INC_HI:0];
               end
            end
            `DPD_OP_P2: begin
               if (instr_word[`DPD_P2_ESC_EN]) begin
                  s_nxt.esc_cr = instr_word[`DPD_P2_ESC_EN-1];
               end
               if (instr_word[`DPD_P2_FLASH_EN]) begin
                  s_nxt.flash = instr_word[`DPD_P2_FLASH_EN-1];
               end
               if (instr_word[`DPD_P2_BORDER_EN]) begin
                  s_nxt.border_det = instr_word[`DPD_P2_BORDER_EN-1];
               end
               if (instr_word[`DPD_P2_TURN_EN]) begin
                  s_nxt.turn = instr_word[`DPD_P2_TURN_EN-1];
               end
               if (instr_word[`DPD_P2_PEN_EN]) begin
                  s_nxt.pen_det = instr_word[`DPD_P2_PEN_EN-1];
               end
               if (instr_word[`DPD_P2_MINOR_EN]) begin
                  s_nxt.minor_area = instr_word[`DPD_P2_MINOR_EN-1];
               end
            end
            `DPD_OP_P3: begin
               s_nxt.irq_global = instr_word[`DPD_P3_GLOBAL];
               s_nxt.irq_halt = instr_word[`DPD_P3_HALT];
               s_nxt.irq_pen = instr_word[`DPD_P3_PEN];
               s_nxt.irq_border = instr_word[`DPD_P3_BORDER];
               s_nxt.irq_button = instr_word[`DPD_P3_BUTTON];
               s_nxt.line_type = instr_word[1:0];
            end
            `DPD_OP_SKIP: begin
               s_nxt.skip_a = (skip_code == `DPD_SKIP_A);
               s_nxt.skip_b = (skip_code == `DPD_SKIP_B);
            end
            default: begin
               s_nxt.skip_a = 1'b0;
            end
         endcase
      end

      // Stop, pen and edge flags halt the display file
      // halt from stop
      s_nxt.halt = s_nxt.stop_flag || s_nxt.pen_flag ||
                   s_nxt.border_flag;
      s_nxt.instr_ready = !s_nxt.halt;

      s_nxt.irq_req = s_nxt.irq_global &&
                      ((s_nxt.stop_flag && s_nxt.irq_halt) ||
                       (s_nxt.pen_flag && s_nxt.irq_pen) ||
                       (s_nxt.border_flag && s_nxt.irq_border) ||
                       (s_nxt.button_flag && s_nxt.irq_button));
   end

   // State register with clock enable and synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.brightness <= `DPD_RST_BRT;
         s_r.increment <= `DPD_RST_INC;
         s_r.instr_ready <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Bus outputs straight from the state register
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;

   // Control and skip outputs
   // stop flag as skip condition
   assign instr_ready = s_r.instr_ready;
   assign halt = s_r.halt;
   assign stop_flag = s_r.stop_flag;
   assign pen_flag = s_r.pen_flag;
   assign border_flag = s_r.border_flag;
   assign button_flag = s_r.button_flag;
   assign prog_irq_req = s_r.irq_req;
   assign skip_a_pulse = s_r.skip_a;
   assign skip_b_pulse = s_r.skip_b;

   // Stored parameters held steady for the drawing datapath
   // parameters read during drawing
   assign brightness = s_r.brightness;
   assign increment = s_r.increment;
   assign esc_cr = s_r.esc_cr;
   assign flash = s_r.flash;
   assign border_detect = s_r.border_det;
   assign turn = s_r.turn;
   assign pen_detect = s_r.pen_det;
   assign minor_area = s_r.minor_area;
   assign line_type = s_r.line_type;

endmodule

// ### tb/dpd_props.sv
// Checker for the decoder: instruction takes and parameter loads.
// Assumes binding into dpd_decoder; printed bit n sits at index 17-n.
`timescale 1ns/1ps
`include "dpd_map.svh"
module dpd_props #(
   parameter int INSTR_W = 18
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, low
   input wire logic ce, // Clock enable
   input wire logic [INSTR_W-1:0] instr_word, // Fetched word
   input wire logic instr_valid, // Word offered
   input wire logic instr_ready, // Word taken
   input wire logic halt, // Halted
   input wire logic stop_flag, // Stop flag
   input wire logic prog_irq_req, // Interrupt request
   input wire logic skip_a_pulse, // Skip 230 seen
   input wire logic skip_b_pulse, // Skip 234 seen
   input wire logic [2:0] brightness, // Brightness
   input wire logic [3:0] increment, // Increment
   input wire logic esc_cr, // Escape mode
   input wire logic flash, // Blink
   input wire logic [1:0] line_type // Line type
);
   logic tk, p1t, p2t, p3t;
   logic [5:0] op;
   logic [8:0] code;
   // Take decode
   assign tk = ce && instr_valid && instr_ready;
   assign op = instr_word[INSTR_W-1 -: 6];
   assign code = instr_word[INSTR_W-1 -: 9];
   assign p1t = tk && op == `DPD_OP_P1;
   assign p2t = tk && op == `DPD_OP_P2;
   assign p3t = tk && op == `DPD_OP_P3;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_stop_halts: assert property (
      p1t && instr_word[11] |=> stop_flag && halt && !instr_ready)
      else $error("stop word did not halt");
   a_halt_stall: assert property (
      halt |-> !instr_ready ##1 ($stable(brightness) && $stable(increment)))
      else $error("ready or parameter change while halted");
   a_brt_load: assert property (
      p1t && instr_word[10] |=> brightness == $past(instr_word[9:7]))
      else $error("brightness not loaded");
   a_brt_hold: assert property (
      p1t && !instr_word[10] |=> $stable(brightness))
      else $error("brightness changed without enable");
   a_inc_load: assert property (
      p1t && instr_word[4] |=> increment == $past(instr_word[3:0]))
      else $error("increment not loaded");
   a_flash_load: assert property (
      p2t && instr_word[9] |=> flash == $past(instr_word[8]))
      else $error("blink not loaded");
   a_esc_hold: assert property (
      p2t && !instr_word[11] |=> $stable(esc_cr))
      else $error("escape changed without enable");
   a_line_load: assert property (
      p3t |=> line_type == $past(instr_word[1:0]))
      else $error("line type not loaded");
   a_irq_gate: assert property (
      p3t && !instr_word[7] ##1 !p3t |=> !prog_irq_req)
      else $error("interrupt without global enable");
   a_skip_code: assert property (
      tk && code == `DPD_SKIP_A |=> skip_a_pulse)
      else $error("skip 230 missed");
   a_skip_cause: assert property (
      skip_b_pulse |-> $past(tk && code == `DPD_SKIP_B))
      else $error("skip 234 pulse without cause");
endmodule
bind dpd_decoder dpd_props #(.INSTR_W(INSTR_W)) u_props (.*);

// ### tb/dpd_fetch_model.sv
// Display file fetch model: offers queued words one at a time.
// Assumes the decoder takes a word at an edge with valid and ready.
`timescale 1ns/1ps
module dpd_fetch_model (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, low
   input wire logic instr_ready, // Decoder takes word
   output logic [17:0] instr_word, // Offered word
   output logic instr_valid // Word offered
);
   logic [17:0] q[$];
   initial begin
      instr_valid = 1'b0;
      instr_word = 18'h00000;
   end
   // Hold each word until taken; idle word toggles every cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         instr_valid <= 1'b0;
      end else if (!instr_valid || instr_ready) begin
         if (q.size() > 0) begin
            instr_word <= q.pop_front();
            instr_valid <= 1'b1;
         end else begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
         end
      end
   end
endmodule

// ### tb/dpd_decoder_tb.sv
// Testbench: display words through the fetch model, status over AXI.
// Assumes the map header and a 50 MHz clock.
`timescale 1ns/1ps
`include "dpd_map.svh"
module dpd_decoder_tb;
   logic aclk, aresetn, ce, instr_valid, instr_ready, border_exceed;
   logic pen_hit_pin, button_pin, halt, stop_flag, pen_flag;
   logic border_flag, button_flag, prog_irq_req, skip_a_pulse;
   logic skip_b_pulse, esc_cr, flash, border_detect, turn;
   logic pen_detect, minor_area;
   logic [17:0] instr_word;
   logic [2:0] brightness, s_axi_awprot, s_axi_arprot;
   logic [3:0] increment, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [1:0] line_type, s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [5:0] p2v;
   int err_count = 0;
   int check_count = 0;
   int na = 0;
   int nb = 0;
   dpd_decoder dut (.*);
   dpd_fetch_model fm (.aclk, .aresetn, .instr_ready, .instr_word,
      .instr_valid);
   assign p2v = {esc_cr, flash, border_detect, turn, pen_detect, minor_area};
   // Clock at 20 ns
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // Skip pulse counters
   always @(posedge aclk) begin
      if (skip_a_pulse === 1'b1) na++;
      if (skip_b_pulse === 1'b1) nb++;
   end
   function automatic logic [17:0] p1(input logic s, input logic be,
      input logic [2:0] b, input logic ie, input logic [3:0] i);
      return {`DPD_OP_P1, s, be, b, 2'b11, ie, i};
   endfunction
   function automatic logic [17:0] p3(input logic g, input logic h,
      input logic [1:0] lt);
      return {`DPD_OP_P3, 4'hF, g, h, 3'b000, 1'b1, lt};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task idle();
      int n;
      n = 0;
      @(posedge aclk);
      do begin
         @(posedge aclk);
         n++;
      end while (instr_valid === 1'b1 && n < 20);
   endtask
   task send(input logic [17:0] w);
      fm.q.push_back(w);
      idle();
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Hang guard
   initial begin
      repeat (30000) @(posedge aclk);
      err_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      {aresetn, border_exceed, pen_hit_pin, button_pin} = 4'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      {s_axi_awprot, s_axi_arprot} = 6'h00;
      s_axi_wstrb = 4'hF;
      ce = 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(instr_ready, 1);
      rd(`DPD_OFF_STAT2);
      chk(rv, 32'h0F);
      send(p1(0, 1, 3'h3, 1, 4'hF));
      chk(brightness, 3);
      chk(increment, 15);
      send(p1(0, 0, 3'h5, 0, 4'h2));
      chk({brightness, increment}, 7'h3F);
      rd(`DPD_OFF_STAT2);
      chk(rv, 32'h7B);
      for (int b = 0; b < 8; b++) begin
         send(p1(0, 1, 3'(b), 1, 4'h1));
         chk(brightness, b);
      end
      send({`DPD_OP_P2, 12'hFFF});
      chk(p2v, 6'h3F);
      send({`DPD_OP_P2, 12'h555});
      chk(p2v, 6'h3F);
      send({`DPD_OP_P2, 12'hAAA});
      chk(p2v, 6'h00);
      for (int i = 0; i < 6; i++) begin
         send({`DPD_OP_P2, 12'(12'h003 << (10 - 2 * i))});
         chk(p2v, 6'(6'h3F << (5 - i)));
      end
      send(p3(0, 1, 2'h2));
      chk(line_type, 2);
      send(p1(1, 0, 3'h0, 0, 4'h0));
      chk({stop_flag, halt, instr_ready}, 3'b110);
      chk(prog_irq_req, 0);
      rd(`DPD_OFF_STAT3);
      chk(rv, 32'h21);
      wr(`DPD_OFF_CTRL, 32'h1);
      chk(stop_flag, 0);
      send(p3(1, 1, 2'h1));
      send(p1(1, 0, 3'h0, 0, 4'h0));
      chk(prog_irq_req, 1);
      rd(`DPD_OFF_STAT3);
      chk(rv, 32'h231);
      send(p1(0, 1, 3'h0, 0, 4'h0));
      chk({instr_valid, brightness}, 4'hF);
      wr(`DPD_OFF_CTRL, 32'h1);
      idle();
      chk({prog_irq_req, brightness}, 4'h0);
      // Restore the original scale after one-off change
      send(p1(0, 0, 3'h0, 1, 4'h1));
      fm.q.push_back({`DPD_SKIP_A, 9'h1FF});
      fm.q.push_back({`DPD_SKIP_B, 9'h1FF});
      send({9'h09A, 9'h1FF});
      chk(na * 16 + nb, 17);
      send(18'h14FFF);
      chk({brightness, increment, p2v}, 13'h07F);
      chk(line_type, 1);
      send({`DPD_OP_P2, 12'h0CC});
      border_exceed <= 1'b1;
      @(posedge aclk);
      border_exceed <= 1'b0;
      {pen_hit_pin, button_pin} <= 2'b11;
      repeat (5) @(posedge aclk);
      {pen_hit_pin, button_pin} <= 2'b00;
      repeat (2) @(posedge aclk);
      rd(`DPD_OFF_STAT3);
      chk(rv, 32'h3E);
      chk({pen_flag, border_flag, button_flag}, 3'b111);
      chk({halt, prog_irq_req}, 2'b10);
      wr(`DPD_OFF_CTRL, 32'hE);
      chk(rs, `DPD_RESP_OKAY);
      rd(`DPD_OFF_STAT3);
      chk(rv, 32'h30);
      // Clock enable low freezes the edge flag
      ce <= 1'b0;
      border_exceed <= 1'b1;
      @(posedge aclk);
      border_exceed <= 1'b0;
      ce <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(border_flag, 0);
      rd(4'hC);
      chk(rs, `DPD_RESP_SLVERR);
      chk(rv, 32'h0);
      tally_and_finish();
   end
endmodule
